// >>> verilog/sac_pkg.sv
package sac_pkg;
    // clock rate and period
    localparam int CLK_MHZ       = 20;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;

    // times in ns
    localparam int T_ACQ_NS      = 150;
    localparam int T_CONV_LO_NS  = 20;
    localparam int T_CONV_HI_NS  = 20;
    localparam int T_HOLD1_NS    = 40;
    localparam int T_RD_LO_NS    = 50;
    localparam int T_RD_HI_NS    = 20;
    localparam int T_SEL_HI_NS   = 20;
    localparam int T_EN_NS       = 30;
    localparam int T_BYTE_NS     = 30;
    localparam int T_HOLD2_NS    = 50;
    localparam int T_BUSY_MAX_NS = 610;
    localparam int T_PD1_NS      = 50;

    // cycle counts; minimums round up
    localparam int C_ACQ     = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_CONV_LO = (T_CONV_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_CONV_HI = (T_CONV_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_HOLD1   = (T_HOLD1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_RD_LO   = (T_RD_LO_NS + T_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_RD_HI   = (T_RD_HI_NS + T_BYTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_SEL_HI  = (T_SEL_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_HOLD2   = (T_HOLD2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_BUSY_TO = (T_BUSY_MAX_NS + T_PD1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 6;
    localparam logic [15:0] SAMPLE_RESET = 16'h0000;

    typedef enum logic [3:0] {
        S_IDLE, S_SEL, S_ACQ, S_CONV_LO, S_CONV_HI, S_WAIT_BUSY,
        S_RD_HI_LO, S_RD_HI_GAP, S_RD_LO_LO, S_DESEL, S_HOLD
    } sac_state_t;
endpackage

// >>> verilog/sac_host.sv
`timescale 1ns/100ps
// Overview of operation
// - host keeps at least 150 ns acquisition between conversions.
// - host holds trigger low at least 20 ns.
// - host holds trigger high at least 20 ns between pulses.
// - host lowers select no later than trigger falls.
// - read strobe, select and byte select steady 40 ns after trigger falls.
// - each read strobe low pulse lasts at least 50 ns.
// - read strobe high at least 20 ns between pulses.
// - select high time at least 20 ns.
// - read strobe rises no later than select rises.
// - byte select changes no later than read strobe falls.
// - host waits 50 ns after last strobe before next trigger.
module sac_host
    import sac_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // user side
    input  wire logic        START_I,
    output logic             READY_O,
    output logic [15:0]      SAMPLE_O,
    output logic             SAMPLE_VALID_O,
    output logic             TIMEOUT_O,
    // converter pins
    output logic             CONV_TRIGGER_N_O,
    output logic             SELECT_N_O,
    output logic             READ_N_O,
    output logic             BYTE_SEL_O,
    input  wire logic        BUSY_I,
    input  wire logic [7:0]  DATA_HI_I
);
    sac_state_t             state_reg, state_next;
    logic [CNT_W-1:0]       cnt_reg, cnt_next;
    logic [7:0]             msb_reg, msb_next;
    logic [15:0]            sample_reg, sample_next;
    logic                   valid_reg, valid_next;
    logic                   tout_reg, tout_next;
    logic                   conv_n_reg, conv_n_next;
    logic                   sel_n_reg, sel_n_next;
    logic                   rd_n_reg, rd_n_next;
    logic                   byte_reg, byte_next;

    wire cnt_done = (cnt_reg == '0);
    wire [CNT_W-1:0] cnt_dec = cnt_reg - 6'h01;

    assign READY_O          = (state_reg == S_IDLE);
    assign SAMPLE_O         = sample_reg;
    assign SAMPLE_VALID_O   = valid_reg;
    assign TIMEOUT_O        = tout_reg;
    assign CONV_TRIGGER_N_O = conv_n_reg;
    assign SELECT_N_O       = sel_n_reg;
    assign READ_N_O         = rd_n_reg;
    assign BYTE_SEL_O       = byte_reg;

    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_done ? cnt_reg : cnt_dec;
        msb_next    = msb_reg;
        sample_next = sample_reg;
        valid_next  = 1'b0;
        tout_next   = 1'b0;
        conv_n_next = conv_n_reg;
        sel_n_next  = sel_n_reg;
        rd_n_next   = rd_n_reg;
        byte_next   = byte_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (START_I) begin
                    sel_n_next = 1'b0;
                    byte_next  = 1'b0;
                    cnt_next   = CNT_W'(C_ACQ - 1);
                    state_next = S_ACQ;
                end
            end
            S_SEL: state_next = S_ACQ;
            S_ACQ: begin
                if (cnt_done) begin
                    conv_n_next = 1'b0;
                    cnt_next    = CNT_W'(C_CONV_LO - 1);
                    state_next  = S_CONV_LO;
                end
            end
            S_CONV_LO: begin
                if (cnt_done) begin
                    conv_n_next = 1'b1;
                    cnt_next    = CNT_W'(C_BUSY_TO - 1);
                    state_next  = S_CONV_HI;
                end
            end
            S_CONV_HI: begin
                // pins steady after trigger, busy may not rise yet
                if (cnt_reg <= CNT_W'(C_BUSY_TO - C_HOLD1 - 1)) state_next = S_WAIT_BUSY;
            end
            S_WAIT_BUSY: begin
                if (!BUSY_I) begin
                    rd_n_next  = 1'b0;
                    cnt_next   = CNT_W'(C_RD_LO - 1);
                    state_next = S_RD_HI_LO;
                end else if (cnt_done) begin
                    // converter hung: give up and release the bus
                    tout_next  = 1'b1;
                    sel_n_next = 1'b1;
                    cnt_next   = CNT_W'(C_HOLD2 - 1);
                    state_next = S_HOLD;
                end
            end
            S_RD_HI_LO: begin
                if (cnt_done) begin
                    msb_next   = DATA_HI_I;
                    rd_n_next  = 1'b1;
                    byte_next  = 1'b1;
                    cnt_next   = CNT_W'(C_RD_HI - 1);
                    state_next = S_RD_HI_GAP;
                end
            end
            S_RD_HI_GAP: begin
                // strobe high gap, covers byte settle
                if (cnt_done) begin
                    rd_n_next  = 1'b0;
                    cnt_next   = CNT_W'(C_RD_LO - 1);
                    state_next = S_RD_LO_LO;
                end
            end
            S_RD_LO_LO: begin
                if (cnt_done) begin
                    // low byte folded onto upper lines
                    sample_next = {msb_reg, DATA_HI_I};
                    valid_next  = 1'b1;
                    rd_n_next   = 1'b1;
                    state_next  = S_DESEL;
                end
            end
            S_DESEL: begin
                sel_n_next = 1'b1;
                byte_next  = 1'b0;
                cnt_next   = CNT_W'(C_HOLD2 - 1);
                state_next = S_HOLD;
            end
            S_HOLD: begin
                if (cnt_done) state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_reg  <= S_IDLE;
            cnt_reg    <= '0;
            msb_reg    <= 8'h00;
            sample_reg <= SAMPLE_RESET;
            valid_reg  <= 1'b0;
            tout_reg   <= 1'b0;
            conv_n_reg <= 1'b1;
            sel_n_reg  <= 1'b1;
            rd_n_reg   <= 1'b1;
            byte_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            msb_reg    <= msb_next;
            sample_reg <= sample_next;
            valid_reg  <= valid_next;
            tout_reg   <= tout_next;
            conv_n_reg <= conv_n_next;
            sel_n_reg  <= sel_n_next;
            rd_n_reg   <= rd_n_next;
            byte_reg   <= byte_next;
        end
    end

    // helper: cycles since trigger fell, saturating at 255
    logic [7:0] since_conv;
    always_ff @(posedge CLK_I) begin
        if (RST_I) since_conv <= 8'hff;
        else if (conv_n_reg && !conv_n_next) since_conv <= 8'h00;
        else if (since_conv != 8'hff) since_conv <= since_conv + 8'h01;
    end

    sequence seq_trig_fall;
        $fell(conv_n_reg);
    endsequence

    AST_TRIG_LOW: assert property (@(posedge CLK_I) disable iff (RST_I)
        seq_trig_fall |-> (!conv_n_reg)[*1] ##1 conv_n_reg)
        else $error("trigger low too short");
    AST_SEL_BEFORE_TRIG: assert property (@(posedge CLK_I) disable iff (RST_I)
        $fell(conv_n_reg) |-> !sel_n_reg && !$past(sel_n_reg))
        else $error("select not low at trigger");
    AST_PINS_STEADY: assert property (@(posedge CLK_I) disable iff (RST_I)
        (since_conv < 8'(C_HOLD1)) |-> $stable(rd_n_reg) && $stable(byte_reg) && $stable(sel_n_reg))
        else $error("pins moved too soon after trigger");
    AST_RD_LOW: assert property (@(posedge CLK_I) disable iff (RST_I)
        $fell(rd_n_reg) |-> (!rd_n_reg)[*2])
        else $error("read strobe low too short");
    AST_RD_HIGH: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(byte_reg) |-> rd_n_reg ##1 !rd_n_reg)
        else $error("read strobe high too short");
    AST_SEL_HIGH: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(sel_n_reg) |=> sel_n_reg)
        else $error("select high too short");
    AST_RD_BEFORE_SEL: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(sel_n_reg) |-> rd_n_reg)
        else $error("select rose with strobe low");
    AST_BYTE_STROBE: assert property (@(posedge CLK_I) disable iff (RST_I)
        !$stable(byte_reg) |-> rd_n_reg)
        else $error("byte select moved during strobe");
    AST_READ_AFTER_BUSY: assert property (@(posedge CLK_I) disable iff (RST_I)
        $fell(rd_n_reg) |-> !$past(BUSY_I))
        else $error("read started while busy");
    AST_HOLD_GAP: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(sel_n_reg) |-> (conv_n_reg)[*3])
        else $error("trigger too soon after read");
endmodule

// >>> verif/sac_adc_model.sv
`timescale 1ns/100ps
module sac_adc_model (
    // converter pins
    input  wire logic        trig_n_i,
    input  wire logic        sel_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        byte_i,
    output logic             busy_o,
    output logic [7:0]       data_o,
    // test controls
    input  wire logic [15:0] result_i,
    input  wire logic        stuck_i,
    input  int               conv_ns_i
);
    logic [15:0] held;
    logic        acq;
    initial begin
        busy_o = 1'b0;
        data_o = 8'h5a;
        held = 16'h0000;
        acq = 1'b0;
    end
    always @(negedge sel_n_i) acq = 1'b1;
    // trigger fall ends acquisition, busy up in 30 ns
    always @(negedge trig_n_i) begin
        if (!busy_o && acq) begin
            acq = 1'b0;
            #30 busy_o = 1'b1;
            #(conv_ns_i - 30);
            // stuck only where a scenario asks for a dead converter
            wait (!stuck_i);
            held = result_i;
            // busy drops 5 ns after conversion end
            #5 busy_o = 1'b0;
        end
    end
    // half chosen by byte select; a released bus shows the inverse
    always @(sel_n_i or rd_n_i or byte_i or held) begin
        if (!sel_n_i && !rd_n_i) data_o <= #20 (byte_i ? held[7:0] : held[15:8]);
        else data_o <= #20 ~data_o;
    end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        clk, rst, start, ready, valid, tout, stuck;
    logic        trig_n, sel_n, rd_n, byte_sel, busy;
    logic [15:0] sample, result;
    logic [7:0]  data_hi;
    int          conv_ns, err_count, checks_done, cycles, n_trig;
    realtime     t_tf, t_rf, t_rr, t_bf;

    sac_host u_sac_host (
        .CLK_I(clk), .RST_I(rst), .START_I(start), .READY_O(ready),
        .SAMPLE_O(sample), .SAMPLE_VALID_O(valid), .TIMEOUT_O(tout),
        .CONV_TRIGGER_N_O(trig_n), .SELECT_N_O(sel_n), .READ_N_O(rd_n),
        .BYTE_SEL_O(byte_sel), .BUSY_I(busy), .DATA_HI_I(data_hi)
    );
    sac_adc_model u_sac_adc_model (
        .trig_n_i(trig_n), .sel_n_i(sel_n), .rd_n_i(rd_n), .byte_i(byte_sel),
        .busy_o(busy), .data_o(data_hi), .result_i(result), .stuck_i(stuck),
        .conv_ns_i(conv_ns)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // hang guard well above the five scenarios
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            wrap_up();
        end
    end

    // pin timing seen at the converter
    always @(negedge busy) t_bf = $realtime;
    always @(negedge trig_n) begin
        n_trig++;
        check(sel_n === 1'b0, "select late");
        check($realtime - t_bf >= 150.0, "acquisition short");
        check($realtime - t_rr >= 50.0, "trigger after read");
        t_tf = $realtime;
    end
    always @(posedge trig_n) if (!rst) check($realtime - t_tf >= 20.0, "trigger pulse");
    always @(negedge rd_n) if (!rst) t_rf = $realtime;
    always @(posedge rd_n) if (!rst) begin
        check($realtime - t_rf >= 50.0, "read pulse");
        t_rr = $realtime;
    end
    always @(posedge sel_n) if (!rst) check(rd_n === 1'b1, "select before read");

    // one conversion; hold keeps start up to see it ignored while busy
    task automatic run_conv(input logic [15:0] val, input int ns, input logic hold);
        int n, t0;
        result = val;
        conv_ns = ns;
        t0 = n_trig;
        n = 0;
        // start only counts while the host is idle
        while (ready !== 1'b1) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = hold;
        while (valid !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        start = 1'b0;
        check(valid === 1'b1 && sample === val, "sample wrong");
        check(tout === 1'b0 && n_trig == t0 + 1, "extra trigger");
    endtask

    task automatic check_reset;
        check({ready, trig_n, sel_n, rd_n} === 4'hf, "idle pins");
        check({byte_sel, valid, tout} === 3'h0 && sample === 16'h0000, "idle outputs");
    endtask

    // busy never falls: timeout and no sample, then recovery
    task automatic dead_converter;
        int n;
        while (ready !== 1'b1) @(negedge clk);
        stuck = 1'b1;
        start = 1'b1;
        n = 0;
        @(negedge clk);
        start = 1'b0;
        while (tout !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
            check(valid === 1'b0, "sample during stall");
        end
        check(tout === 1'b1, "no timeout");
        stuck = 1'b0;
        repeat (20) @(negedge clk);
        run_conv(16'h3c96, 500, 1'b0);
    endtask

    initial begin
        {rst, start, stuck, result} = {1'b1, 1'b0, 1'b0, 16'h0000};
        {conv_ns, err_count, checks_done, cycles, n_trig} = {32'd500, 128'd0};
        t_tf = 0.0;
        t_rf = 0.0;
        t_rr = 0.0;
        t_bf = 0.0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        check_reset();
        run_conv(16'ha5c3, 500, 1'b0);
        run_conv(16'h8001, 600, 1'b1);
        run_conv(16'hffff, 550, 1'b0);
        run_conv(16'h0000, 500, 1'b0);
        dead_converter();
        wrap_up();
    end
endmodule
